// ==== hw/gacc_pkg.sv ====
// Constants, register map and types of the gas alarm channel controller
package gacc_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int HALF_SEC_MS     = 500;
  localparam int HALF_SEC_CYCLES = HALF_SEC_MS * 1000000 / CLK_PERIOD_NS;
  localparam int VERSION_MS      = 500;
  localparam int VERSION_TICKS   = VERSION_MS / HALF_SEC_MS;
  localparam int VER_NUM_MS      = 500;
  localparam int VER_NUM_TICKS   = VER_NUM_MS / HALF_SEC_MS;
  localparam int WARMUP_S        = 30;
  localparam int WARMUP_TICKS    = WARMUP_S * 1000 / HALF_SEC_MS;
  localparam int HOLD_S          = 2;
  localparam int HOLD_TICKS      = HOLD_S * 1000 / HALF_SEC_MS;
  localparam int TIMEOUT_MIN     = 30;
  localparam int TIMEOUT_TICKS   = TIMEOUT_MIN * 60 * 1000 / HALF_SEC_MS;
  localparam int TICKS_PER_SEC   = 1000 / HALF_SEC_MS;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SCALE  = 8'h04;
  localparam logic [7:0] REG_ALARM1 = 8'h08;
  localparam logic [7:0] REG_ALARM2 = 8'h0C;
  localparam logic [7:0] REG_ALARM3 = 8'h10;
  localparam logic [7:0] REG_NET    = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_SIM    = 8'h1C;
  localparam logic [7:0] REG_VALUE  = 8'h20;

  localparam int CTRL_LATCH  = 0;
  localparam int CTRL_ENERG  = 1;
  localparam int CTRL_LAMP   = 2;
  localparam int CTRL_ETO    = 3;
  localparam int SCALE_DP    = 16;
  localparam int ALM_DB      = 16;
  localparam int ALM_DWELL   = 24;
  localparam int ALM_DIR     = 31;
  localparam int NET_PAR     = 8;
  localparam int ST_ACTIVE   = 4;
  localparam int ST_UNDER    = 7;
  localparam int ST_OVER     = 8;
  localparam int ST_SILENCE  = 9;

  localparam logic [3:0]  CTRL_DEF  = 4'h5;
  localparam logic [13:0] HS_MIN    = 14'h000A;
  localparam logic [13:0] HS_MAX    = 14'h270F;
  localparam logic [13:0] HS_DEF    = 14'h0064;
  localparam logic [1:0]  DP_DEF    = 2'h0;
  localparam logic [5:0]  DWELL_MAX = 6'h3C;
  localparam logic [5:0]  DWELL_DEF = 6'h01;
  localparam logic [6:0]  DB_MAX    = 7'h63;
  localparam logic [6:0]  DB_DEF    = 7'h00;
  localparam logic [7:0]  STN_MAX   = 8'h80;
  localparam logic [7:0]  STN_DEF   = 8'h01;
  localparam logic [1:0]  PAR_MAX   = 2'h2;
  localparam logic [1:0]  PAR_DEF   = 2'h1;
  localparam logic [41:0] THR_DEF   = {14'h0032, 14'h0028, 14'h0014};
  localparam logic [15:0] FW_VERSION = 16'h00CB;

  localparam logic [2:0] LBL_NUMBER  = 3'h0;
  localparam logic [2:0] LBL_VERSION = 3'h1;
  localparam logic [2:0] LBL_SELF    = 3'h2;
  localparam logic [2:0] LBL_UNDER   = 3'h3;
  localparam logic [2:0] LBL_OVER    = 3'h4;
  localparam logic [2:0] LBL_FAULT   = 3'h5;
  localparam logic [1:0] BAR_GREEN   = 2'h1;
  localparam logic [1:0] BAR_ORANGE  = 2'h2;
  localparam logic [1:0] BAR_RED     = 2'h3;

  typedef enum logic [2:0] {
    M_VER_LABEL, M_VER_NUM, M_WARMUP, M_FAULT, M_MEASURE, M_TEST,
    M_SELFTEST, M_STANDBY
  } gacc_mode_t;
endpackage

// ==== hw/gacc_top.sv ====
// Gas alarm channel controller: modes, alarms, indications, AHB registers
//
// Function
// [RULE1] Version label 0.5 s, then version number
// [RULE2] Self label flashes 30 s, then measure/fault
// [RULE3] Bar color by level; thresholds always marked (code: marks off in warm-up and self-test)
// [RULE4] Under-range label flashes, 1 s period
// [RULE5] Under-range: trouble on, lamp flashes, buzzer
// [RULE6] Silence key: buzzer off, lamp steady
// [RULE7] Over-range: label, alarm LEDs, lamp flicker, buzzer
// [RULE8] Alarm after dwell; dwell timer restarts on clear
// [RULE9] Latching holds alarm and peak until reset
// [RULE10] Non-latching alarm releases when condition clears
// [RULE11] Test key held 2 s enters test
// [RULE12] Test exits after 30 min idle or reset
// [RULE13] Test key adjusts simulated concentration
// [RULE14] Function key 2 s starts display self-test
// [RULE15] Down key held 2 s enters stand-by
// [RULE16] Emergency timeout returns after 30 min
// [RULE17] Without timeout, down key 2 s returns
// [RULE18] Stand-by flickers indicator, inhibits relays
// [RULE19] Decimal position and high-scale ranges, defaults
// [RULE20] Dwell 0..60 default 1, dead-band 0..99
// [RULE21] Station 0..128 default 1, parity 0..2
// [RULE22] High direction at/above, low at/below threshold
// [RULE23] Energizer selects relay rest state
// [RULE24] Common 50% flash from free-running divider
`timescale 1ns/1ps
module gacc_top
  import gacc_pkg::*;
#(
  parameter int HALF_SEC = HALF_SEC_CYCLES
)(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic signed [15:0] conc_in,
  input  wire logic               detector_absent,
  input  wire logic               fault_in,
  input  wire logic               test_key,
  input  wire logic               function_key,
  input  wire logic               down_key,
  input  wire logic               reset_key,
  input  wire logic               buzzer_silence_key,
  output logic      [15:0]        seg_value,
  output logic      [2:0]         seg_label,
  output logic                    seg_blank,
  output logic      [1:0]         seg_decimal,
  output logic      [1:0]         bar_color,
  output logic                    bar_top_red,
  output logic                    bar_marks_on,
  output logic      [2:0]         alarm_led,
  output logic                    trouble_led,
  output logic                    standby_indicator,
  output logic                    warn_lamp,
  output logic                    buzzer,
  output logic      [2:0]         alarm_relay,
  output logic                    trouble_relay,
  output logic      [7:0]         station_no,
  output logic      [1:0]         parity_sel
);
  // Half-second tick and common flash phase
  logic [31:0] div_reg, div_next;
  logic        flash_reg, flash_next;
  logic        tick;
  assign tick = (div_reg == 32'(HALF_SEC - 1));
  always_comb
  begin
    div_next   = tick ? 32'h0 : div_reg + 32'h1;
    flash_next = tick ? ~flash_reg : flash_reg; // RULE24
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_reg   <= 32'h0;
      flash_reg <= 1'b0;
    end
    else
    begin
      div_reg   <= div_next;
      flash_reg <= flash_next;
    end
  end

  // Key edges and 2 s hold detectors (test, function, down)
  logic [4:0] keys, key_prev_reg, key_edge;
  logic [2:0] hold_fire;
  assign keys = {buzzer_silence_key, reset_key, down_key, function_key,
                 test_key};
  assign key_edge = keys & ~key_prev_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      key_prev_reg <= 5'h0;
    else
      key_prev_reg <= keys;
  end
  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_hold
      logic [2:0] hcnt_reg, hcnt_next;
      assign hold_fire[k] = keys[k] && tick &&
                            (hcnt_reg == 3'(HOLD_TICKS - 1));
      always_comb
      begin
        hcnt_next = hcnt_reg;
        if (!keys[k])
          hcnt_next = 3'h0;
        else if (tick && hcnt_reg != 3'(HOLD_TICKS))
          hcnt_next = hcnt_reg + 3'h1;
      end
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          hcnt_reg <= 3'h0;
        else
          hcnt_reg <= hcnt_next;
      end
    end
  endgenerate

  // Configuration registers and AHB-Lite slave
  logic [3:0]  ctrl_reg, ctrl_next;
  logic [13:0] hs_reg, hs_next;
  logic [1:0]  dp_reg, dp_next;
  logic [7:0]  stn_reg, stn_next;
  logic [1:0]  par_reg, par_next;
  logic [7:0]  wa_reg;
  logic        wen_reg;
  logic        aphase;
  logic [31:0] rdata;
  logic [13:0] thr [3];
  logic [6:0]  db [3];
  logic [5:0]  dwell [3];
  logic [2:0]  dir_hi, cond, active;
  gacc_mode_t  mode_reg, mode_next;
  logic        under_reg, over_reg, sil_reg;
  logic [15:0] sim_reg, peak_reg, val;
  logic [15:0] shown;
  assign aphase = hsel && hready && htrans[1];
  always_comb
  begin
    ctrl_next = ctrl_reg;
    hs_next   = hs_reg;
    dp_next   = dp_reg;
    stn_next  = stn_reg;
    par_next  = par_reg;
    if (wen_reg && wa_reg == REG_CTRL)
      ctrl_next = hwdata[3:0];
    if (wen_reg && wa_reg == REG_SCALE)
    begin
      hs_next = (hwdata[13:0] < HS_MIN) ? HS_MIN :
                (hwdata[13:0] > HS_MAX) ? HS_MAX : hwdata[13:0]; // RULE19
      dp_next = hwdata[SCALE_DP +: 2];
    end
    if (wen_reg && wa_reg == REG_NET)
    begin
      stn_next = (hwdata[7:0] > STN_MAX) ? STN_MAX : hwdata[7:0]; // RULE21
      par_next = (hwdata[NET_PAR +: 2] > PAR_MAX) ? PAR_MAX :
                 hwdata[NET_PAR +: 2];
    end
    case (haddr[7:0])
      REG_CTRL:   rdata = {28'h0, ctrl_reg};
      REG_SCALE:  rdata = {14'h0, dp_reg, 2'h0, hs_reg};
      REG_ALARM1: rdata = {dir_hi[0], 1'b0, dwell[0], 1'b0, db[0], 2'h0,
                           thr[0]};
      REG_ALARM2: rdata = {dir_hi[1], 1'b0, dwell[1], 1'b0, db[1], 2'h0,
                           thr[1]};
      REG_ALARM3: rdata = {dir_hi[2], 1'b0, dwell[2], 1'b0, db[2], 2'h0,
                           thr[2]};
      REG_NET:    rdata = {22'h0, par_reg, stn_reg};
      REG_STATUS: rdata = {22'h0, sil_reg, over_reg, under_reg, active,
                           1'b0, mode_reg};
      REG_SIM:    rdata = {16'h0, sim_reg};
      REG_VALUE:  rdata = {16'h0, shown};
      default:    rdata = 32'h0;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg  <= CTRL_DEF;
      hs_reg    <= HS_DEF;
      dp_reg    <= DP_DEF;
      stn_reg   <= STN_DEF;
      par_reg   <= PAR_DEF;
      wa_reg    <= 8'h0;
      wen_reg   <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      hs_reg   <= hs_next;
      dp_reg   <= dp_next;
      stn_reg  <= stn_next;
      par_reg  <= par_next;
      wa_reg   <= haddr[7:0];
      wen_reg  <= aphase && hwrite;
      if (aphase && !hwrite)
        hrdata <= rdata;
    end
  end

  // Range checks on the input concentration conc_in
  logic signed [19:0] v10, hs20;
  logic               under_now, over_now, trouble;
  assign v10  = 20'(conc_in) * 20'sh0000A;
  assign hs20 = $signed({6'h0, hs_reg});
  assign under_now = detector_absent || (v10 + hs20 < 20'sh0); // RULE4
  assign over_now  = v10 > hs20 * 20'sh0000B; // RULE7
  assign trouble   = under_reg || mode_reg == M_FAULT;

  // Per-alarm settings, condition, dwell timer and latch
  genvar a;
  generate
    for (a = 0; a < 3; a++)
    begin : g_alarm
      logic [31:0]        wd;
      logic [13:0]        thr_reg, thr_next;
      logic [6:0]         db_reg, db_next;
      logic [5:0]         dw_reg, dw_next;
      logic               hi_reg, hi_next, act_reg, act_next;
      logic [7:0]         dcnt_reg, dcnt_next;
      logic signed [17:0] lv, lvl_on;
      assign wd  = hwdata;
      assign lv  = 18'(signed'(val));
      assign lvl_on = hi_reg ?
                      $signed({4'h0, thr_reg}) + $signed({11'h0, db_reg}) :
                      $signed({4'h0, thr_reg}) - $signed({11'h0, db_reg});
      assign cond[a] = hi_reg ? (lv >= lvl_on) : (lv <= lvl_on); // RULE22
      always_comb
      begin
        thr_next  = thr_reg;
        db_next   = db_reg;
        dw_next   = dw_reg;
        hi_next   = hi_reg;
        if (wen_reg && wa_reg == REG_ALARM1 + 8'(4 * a))
        begin
          thr_next = (wd[13:0] > hs_reg) ? hs_reg : wd[13:0];
          db_next  = (wd[ALM_DB +: 7] > DB_MAX) ? DB_MAX : wd[ALM_DB +: 7];
          dw_next  = (wd[ALM_DWELL +: 6] > DWELL_MAX) ? DWELL_MAX :
                     wd[ALM_DWELL +: 6]; // RULE20
          hi_next  = wd[ALM_DIR];
        end
        dcnt_next = !cond[a] ? 8'h0 : // RULE8
                    (tick && dcnt_reg != 8'hFF) ? dcnt_reg + 8'h1 : dcnt_reg;
        act_next  = act_reg;
        if (cond[a] && dcnt_reg >= 8'(TICKS_PER_SEC) * {2'h0, dw_reg})
          act_next = 1'b1; // RULE8
        else if (!cond[a] && !ctrl_reg[CTRL_LATCH])
          act_next = 1'b0; // RULE10
        else if (key_edge[3] && !cond[a])
          act_next = 1'b0; // RULE9
      end
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          thr_reg  <= THR_DEF[14*a +: 14];
          db_reg   <= DB_DEF;
          dw_reg   <= DWELL_DEF;
          hi_reg   <= 1'b1;
          act_reg  <= 1'b0;
          dcnt_reg <= 8'h0;
        end
        else
        begin
          thr_reg  <= thr_next;
          db_reg   <= db_next;
          dw_reg   <= dw_next;
          hi_reg   <= hi_next;
          act_reg  <= act_next;
          dcnt_reg <= dcnt_next;
        end
      end
      assign thr[a]    = thr_reg;
      assign db[a]     = db_reg;
      assign dwell[a]  = dw_reg;
      assign dir_hi[a] = hi_reg;
      assign active[a] = act_reg;
    end
  endgenerate

  // Operating mode sequencer
  logic [11:0] mcnt_reg, mcnt_next;
  logic [15:0] sim_next, peak_next;
  logic        sil_next;
  assign val = (mode_reg == M_TEST || mode_reg == M_SELFTEST) ?
               sim_reg : conc_in; // RULE13
  always_comb
  begin
    mode_next = mode_reg;
    mcnt_next = tick ? mcnt_reg + 12'h1 : mcnt_reg;
    sim_next  = sim_reg;
    case (mode_reg)
      M_VER_LABEL:
        if (tick && mcnt_reg == 12'(VERSION_TICKS - 1))
          mode_next = M_VER_NUM; // RULE1
      M_VER_NUM:
        if (tick && mcnt_reg == 12'(VER_NUM_TICKS - 1))
          mode_next = M_WARMUP;
      M_WARMUP:
        if (tick && mcnt_reg == 12'(WARMUP_TICKS - 1))
          mode_next = fault_in ? M_FAULT : M_MEASURE; // RULE2
      M_FAULT:
        if (!fault_in)
          mode_next = M_MEASURE;
      M_MEASURE:
        if (hold_fire[0])
          mode_next = M_TEST; // RULE11
        else if (hold_fire[2])
          mode_next = M_STANDBY; // RULE15
      M_TEST:
      begin
        if (key_edge[0])
          sim_next = (sim_reg >= {2'h0, hs_reg}) ? 16'h0 : sim_reg + 16'h1;
        if (|key_edge)
          mcnt_next = 12'h0; // RULE12
        if (key_edge[3] ||
            (tick && mcnt_reg == 12'(TIMEOUT_TICKS - 1)))
          mode_next = M_MEASURE; // RULE12
        else if (hold_fire[1])
          mode_next = M_SELFTEST; // RULE14
      end
      M_SELFTEST:
        if (key_edge[3])
          mode_next = M_MEASURE;
      M_STANDBY:
        if (hold_fire[2] || (ctrl_reg[CTRL_ETO] && tick &&
            mcnt_reg == 12'(TIMEOUT_TICKS - 1)))
          mode_next = M_MEASURE; // RULE16 RULE17
      default:
        mode_next = M_MEASURE;
    endcase
    if (mode_next != mode_reg)
      mcnt_next = 12'h0;
    sil_next  = trouble && (sil_reg || key_edge[4]); // RULE6
    peak_next = (ctrl_reg[CTRL_LATCH] && |active &&
                 $signed(peak_reg) > $signed(val)) ? peak_reg : val; // RULE9
  end
  assign shown = peak_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg  <= M_VER_LABEL;
      mcnt_reg  <= 12'h0;
      sim_reg   <= 16'h0;
      peak_reg  <= 16'h0;
      sil_reg   <= 1'b0;
      under_reg <= 1'b0;
      over_reg  <= 1'b0;
    end
    else
    begin
      mode_reg  <= mode_next;
      mcnt_reg  <= mcnt_next;
      sim_reg   <= sim_next;
      peak_reg  <= peak_next;
      sil_reg   <= sil_next;
      under_reg <= under_now;
      over_reg  <= over_now;
    end
  end

  // Indication and relay outputs, all registered
  logic warm, stby, stest;
  assign warm  = mode_reg == M_VER_LABEL || mode_reg == M_VER_NUM ||
                 mode_reg == M_WARMUP;
  assign stby  = mode_reg == M_STANDBY;
  assign stest = mode_reg == M_SELFTEST;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seg_value         <= 16'h0;
      seg_label         <= LBL_VERSION;
      seg_blank         <= 1'b0;
      seg_decimal       <= DP_DEF;
      bar_color         <= BAR_GREEN;
      bar_top_red       <= 1'b0;
      bar_marks_on      <= 1'b0;
      alarm_led         <= 3'h0;
      trouble_led       <= 1'b0;
      standby_indicator <= 1'b0;
      warn_lamp         <= 1'b0;
      buzzer            <= 1'b0;
      alarm_relay       <= 3'h7;
      trouble_relay     <= 1'b1;
      station_no        <= STN_DEF;
      parity_sel        <= PAR_DEF;
    end
    else
    begin
      seg_value   <= (mode_reg == M_VER_NUM) ? FW_VERSION : shown; // RULE1
      seg_label   <= (mode_reg == M_VER_LABEL) ? LBL_VERSION :
                     (mode_reg == M_VER_NUM) ? LBL_NUMBER :
                     (mode_reg == M_WARMUP) ? LBL_SELF :
                     (mode_reg == M_FAULT) ? LBL_FAULT :
                     under_reg ? LBL_UNDER : // RULE4
                     over_reg ? LBL_OVER : LBL_NUMBER; // RULE7
      seg_blank   <= flash_reg && (mode_reg == M_WARMUP || under_reg ||
                     over_reg || mode_reg == M_TEST || stest); // RULE2
      seg_decimal <= dp_reg;
      bar_color   <= stest ? ((mcnt_reg % 12'h3 == 12'h0) ? BAR_GREEN :
                              (mcnt_reg % 12'h3 == 12'h1) ? BAR_ORANGE :
                              BAR_RED) : // RULE14
                     active[1] ? BAR_RED : active[0] ? BAR_ORANGE :
                     BAR_GREEN; // RULE3
      bar_top_red  <= over_reg; // RULE7
      bar_marks_on <= !warm && !stest; // RULE3
      alarm_led   <= (over_reg || stest) ? {3{flash_reg}} : active; // RULE7
      trouble_led <= stest ? flash_reg : trouble; // RULE5
      standby_indicator <= (stby || stest) && flash_reg; // RULE18
      warn_lamp   <= over_reg ? flash_reg :
                     under_reg ? (sil_reg || flash_reg) : // RULE6
                     (ctrl_reg[CTRL_LAMP] && |active);
      buzzer      <= over_reg || (under_reg && !sil_reg) || |active; // RULE5
      alarm_relay <= (active & {3{!stby && !warm}}) ^
                     {3{!ctrl_reg[CTRL_ENERG]}}; // RULE18 RULE23
      trouble_relay <= (trouble && !stby) ^ !ctrl_reg[CTRL_ENERG]; // RULE23
      station_no  <= stn_reg;
      parity_sel  <= par_reg;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_hold_test;
    mode_reg == M_MEASURE && hold_fire[0];
  endsequence
  sequence s_silence;
    trouble && key_edge[4] ##1 under_reg;
  endsequence
  ver_to_num_a: assert property ( // RULE1
    mode_reg == M_VER_LABEL && tick |=> mode_reg == M_VER_NUM)
    else $error("version label not followed by number");
  warm_exit_a: assert property ( // RULE2
    mode_reg == M_WARMUP && tick && mcnt_reg == 12'(WARMUP_TICKS - 1)
    |=> mode_reg == (($past(fault_in)) ? M_FAULT : M_MEASURE))
    else $error("warm-up exit wrong");
  silence_buzzer_a: assert property ( // RULE6
    s_silence ##0 (!over_reg && active == 3'h0) |=> !buzzer && warn_lamp)
    else $error("silence key ignored");
  dwell_cause_a: assert property ( // RULE8
    $rose(active[0]) |-> $past(cond[0]))
    else $error("alarm without condition");
  latch_hold_a: assert property ( // RULE9
    ctrl_reg[CTRL_LATCH] && active[0] && !key_edge[3] |=> active[0])
    else $error("latched alarm dropped");
  auto_release_a: assert property ( // RULE10
    !ctrl_reg[CTRL_LATCH] && !cond[0] |=> !active[0])
    else $error("unlatched alarm held");
  test_entry_a: assert property ( // RULE11
    s_hold_test |=> mode_reg == M_TEST ##1 seg_label == LBL_NUMBER ||
    over_reg || under_reg)
    else $error("test hold ignored");
  standby_inhibit_a: assert property ( // RULE18
    stby && $stable(ctrl_reg) |=> trouble_relay == !ctrl_reg[CTRL_ENERG])
    else $error("relay active in stand-by");
  flash_div_a: assert property ( // RULE24
    tick |=> flash_reg != $past(flash_reg) ##1 $stable(flash_reg))
    else $error("flash phase not toggled");
endmodule

// ==== test/gacc_detector_model.sv ====
// Loop transmitter model feeding the channel controller
`timescale 1ns/1ps
module gacc_detector_model (
  input  wire logic               hclk,
  input  wire logic signed [15:0] level,
  input  wire logic               unplug,
  input  wire logic               broken,
  output logic signed [15:0]      conc_in,
  output logic                    detector_absent,
  output logic                    fault_in
);
  // Open loop reads 0 mA, a quarter of the scale below zero
  always_ff @(posedge hclk)
  begin
    conc_in         <= unplug ? 16'hFFE7 : level;
    detector_absent <= unplug;
    fault_in        <= broken;
  end
endmodule

// ==== test/gas_alarm_channel_controller_bench.sv ====
// Testbench of the gas alarm channel controller
`timescale 1ns/1ps
module gas_alarm_channel_controller_bench
  import gacc_pkg::*;
;
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic               hwrite = 1'b0, unplug = 1'b0, broken = 1'b0;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]         htrans = 2'h0, bar_color, parity_sel, seg_decimal;
  logic [2:0]         hsize = 3'h2, seg_label, alarm_led, alarm_relay;
  logic [4:0]         keys = 5'h00;
  logic signed [15:0] level = 16'h0000, conc_in;
  logic [15:0]        seg_value;
  logic [7:0]         station_no;
  logic               hreadyout, hresp, detector_absent, fault_in;
  logic               bar_top_red, bar_marks_on, trouble_led, warn_lamp;
  logic               buzzer, trouble_relay, seg_blank, stby_lit;
  int                 fail_count = 0, num_checks = 0, cnt;

  always #5 hclk = ~hclk;

  gacc_detector_model u_det (.hclk(hclk), .level(level), .unplug(unplug),
    .broken(broken), .conc_in(conc_in), .detector_absent(detector_absent),
    .fault_in(fault_in));

  gacc_top #(.HALF_SEC(20)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conc_in(conc_in),
    .detector_absent(detector_absent), .fault_in(fault_in),
    .test_key(keys[0]), .function_key(keys[1]), .down_key(keys[2]),
    .reset_key(keys[3]), .buzzer_silence_key(keys[4]),
    .seg_value(seg_value), .seg_label(seg_label), .seg_blank(seg_blank),
    .seg_decimal(seg_decimal), .bar_color(bar_color),
    .bar_top_red(bar_top_red), .bar_marks_on(bar_marks_on),
    .alarm_led(alarm_led), .trouble_led(trouble_led),
    .standby_indicator(stby_lit), .warn_lamp(warn_lamp), .buzzer(buzzer),
    .alarm_relay(alarm_relay), .trouble_relay(trouble_relay),
    .station_no(station_no), .parity_sel(parity_sel));

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic hold_key(input int i, input int n);
    @(posedge hclk);
    keys[i] <= 1'b1;
    repeat (n) @(posedge hclk);
    keys[i] <= 1'b0;
    tick(3);
  endtask

  task automatic wait_label(input logic [2:0] l, input int n);
    cnt = 0;
    while (seg_label !== l && cnt < n)
    begin
      tick(1);
      cnt++;
    end
  endtask

  task automatic set_level(input logic [15:0] v, input int n);
    @(posedge hclk);
    level <= v;
    tick(n);
  endtask

  initial
  begin
    tick(20000);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    tick(6);
    check_val(seg_label, LBL_VERSION);
    check_val({alarm_relay, trouble_relay}, 4'hF);
    check_val({station_no, parity_sel}, 10'h005);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wait_label(LBL_NUMBER, 100);
    check_val(seg_value, FW_VERSION);
    wait_label(LBL_SELF, 100);
    wait_label(LBL_NUMBER, 1400);
    check_val(cnt >= 1160 && cnt <= 1240, 1);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h4);
    $display("test power-up done");
    ahb(0, REG_SCALE, 0);
    check_val(rd, 32'h00000064);
    ahb(1, REG_SCALE, 32'h0003FFFF);
    ahb(0, REG_SCALE, 0);
    check_val(rd, 32'h0003270F);
    check_val(seg_decimal, 2'h3);
    ahb(1, REG_SCALE, 32'h00000064);
    ahb(0, REG_ALARM1, 0);
    check_val(rd, 32'h81000014);
    ahb(1, REG_NET, 32'h000003FF);
    tick(1);
    check_val({station_no, parity_sel}, 10'h202);
    ahb(1, 8'h40, 32'hFFFFFFFF);
    ahb(0, 8'h40, 0);
    check_val(rd, 32'h0);
    check_val({hresp, hreadyout}, 2'h1);
    $display("test registers done");
    check_val({bar_color, bar_marks_on}, {BAR_GREEN, 1'b1});
    repeat (3)
    begin
      set_level(16'h0019, 15);
      set_level(16'h0000, 3);
    end
    check_val(alarm_led, 3'h0);
    set_level(16'h0014, 60);
    check_val({alarm_led, alarm_relay}, 6'h0E);
    check_val(bar_color, BAR_ORANGE);
    set_level(16'h0000, 60);
    check_val(alarm_led, 3'h1);
    check_val(seg_value, 16'h0014);
    hold_key(3, 2);
    check_val(alarm_led, 3'h0);
    ahb(1, REG_CTRL, 32'h00000004);
    set_level(16'h0019, 60);
    set_level(16'h0000, 10);
    check_val({alarm_led, alarm_relay}, 6'h07);
    $display("test alarms done");
    hold_key(2, 90);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h7);
    cnt = stby_lit;
    tick(20);
    check_val(cnt ^ stby_lit, 1);
    set_level(16'h0019, 60);
    check_val({alarm_led, alarm_relay}, 6'h0F);
    set_level(16'h0000, 10);
    hold_key(2, 90);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h4);
    $display("test stand-by done");
    hold_key(0, 90);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h5);
    cnt = seg_blank;
    tick(20);
    check_val(cnt ^ seg_blank, 1);
    ahb(0, REG_SIM, 0);
    cnt = rd;
    hold_key(0, 2);
    ahb(0, REG_SIM, 0);
    check_val(rd, cnt + 1);
    hold_key(3, 2);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h4);
    hold_key(0, 90);
    hold_key(1, 90);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h6);
    cnt = alarm_led;
    tick(20);
    check_val(cnt ^ alarm_led, 3'h7);
    hold_key(3, 2);
    ahb(0, REG_STATUS, 0);
    check_val(rd[2:0], 3'h4);
    $display("test test-mode done");
    set_level(16'h006F, 10);
    check_val({seg_label, bar_top_red, buzzer}, {LBL_OVER, 2'h3});
    set_level(16'h0000, 10);
    hold_key(3, 2);
    unplug <= 1'b1;
    tick(10);
    check_val(seg_label, LBL_UNDER);
    check_val({trouble_led, buzzer}, 2'h3);
    hold_key(4, 2);
    check_val({buzzer, warn_lamp}, 2'h1);
    tick(13);
    check_val({buzzer, warn_lamp}, 2'h1);
    unplug <= 1'b0;
    $display("test ranges done");
    @(posedge hclk);
    hresetn <= 1'b0;
    broken  <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_label(LBL_FAULT, 1400);
    check_val(seg_label, LBL_FAULT);
    $display("test fault done");
    report_and_stop();
  end
endmodule
